//--- hw/spst_pkg.sv
// Purpose: shared constants and types of the serial status/transfer port
// Assumes: 100 MHz bus clock, registers as 8-bit words on a 32-bit Wishbone
// Notes:   register indexes become byte addresses as index*4
package spst_pkg;

    // register indexes (byte address = index * 4)
    localparam logic [7:0] IDX_CTRL1  = 8'hE8;
    localparam logic [7:0] IDX_CTRL2  = 8'hE9;
    localparam logic [7:0] IDX_BAUD   = 8'hEA;
    localparam logic [7:0] IDX_STATUS = 8'hEB;
    localparam logic [7:0] IDX_DATA   = 8'hED;
    localparam int unsigned ADR_LO    = 2;
    localparam int unsigned ADR_HI    = 9;

    // status fields and reset
    localparam int unsigned ST_RXF    = 7;
    localparam int unsigned ST_TXE    = 5;
    localparam int unsigned ST_MODE_FAULT_FLAG   = 4;
    localparam logic [7:0] STATUS_RST = 8'h20;

    // control one / two fields and resets
    localparam int unsigned CR1_EN    = 6;
    localparam int unsigned CR1_MST   = 4;
    localparam int unsigned CR1_CPOL  = 3;
    localparam int unsigned CR1_CLOCK_PHASE_SELECT  = 2;
    localparam int unsigned CR1_SSOE  = 1;
    localparam int unsigned CR1_LSBF  = 0;
    localparam int unsigned CR2_FDEN  = 4;
    localparam logic [7:0] CR1_RST    = 8'h04;
    localparam logic [7:0] CR2_RST    = 8'h00;
    localparam logic [7:0] BAUD_RST   = 8'h03;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // transfer format
    localparam logic [4:0] XFER_EDGES = 5'h10;
    localparam int unsigned BYTE_W    = 8;

    // least slave-select high time seen as a real deassertion (half link clock)
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned SS_IDLE_PS    = 62500;
    localparam int unsigned SS_IDLE_CYC   = (SS_IDLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_EDGE, ST_TRAIL, ST_GAP} spst_state_e;

    // one bit per link pin
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spst_pin_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } spst_tick_s;

    typedef struct packed {
        spst_state_e st;
        logic [7:0]  cr1;
        logic [7:0]  cr2;
        logic [7:0]  baud;
        logic        rxf;
        logic        txe;
        logic        mode_fault_flag;
        logic        arm_rx;
        logic        arm_tx;
        logic        arm_mf;
        logic [7:0]  tx_buf;
        logic [7:0]  rx_data;
        logic [7:0]  shreg;
        logic        latched;
        logic [4:0]  edge_cnt;
        logic [3:0]  idle_cnt;
        logic        sck_prev;
        logic        ss_prev;
        logic        ack;
        logic [7:0]  rdat;
        spst_pin_s   po;
        spst_pin_s   poe_n;
    } spst_core_s;

endpackage : spst_pkg

//--- hw/spst_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes:   only the second stage leaves this module
module spst_sync
    import spst_pkg::*;
#(
    parameter int unsigned W = 4
)(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } spst_sync_s;

    spst_sync_s s_q;
    spst_sync_s s_d;

    if (W < 1)
    begin : g_chk
        $error("spst_sync: W must be at least 1");
    end

    always_comb
    begin
        s_d      = s_q;
        s_d.meta = d_i;
        s_d.stab = s_q.meta;
    end

    // idle pins read high, so reset to ones
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '1;
        else if (ce_i)
            s_q <= s_d;
    end

    assign q_o = s_q.stab;

endmodule : spst_sync

//--- hw/spst_tick.sv
// Purpose: half link-clock period tick for the master timing
// Assumes: run_i low for at least one cycle restarts the period
// Notes:   tick_o pulses every div_i+1 cycles while run_i is high
module spst_tick
    import spst_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // control
    input  wire logic       run_i,
    input  wire logic [7:0] div_i,
    output logic            tick_o
);
    spst_tick_s t_q;
    spst_tick_s t_d;

    always_comb
    begin
        t_d      = t_q;
        t_d.tick = 1'b0;
        if (!run_i)
            t_d.cnt = 8'h00;
        else if (t_q.cnt == div_i)
        begin
            t_d.cnt  = 8'h00;
            t_d.tick = 1'b1;
        end
        else
            t_d.cnt = t_q.cnt + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            t_q <= '0;
        else if (ce_i)
            t_q <= t_d;
    end

    assign tick_o = t_q.tick;

endmodule : spst_tick

//--- hw/spst_core.sv
// Purpose: byte-wide serial port, master or slave, with status and data registers
// Assumes: classic Wishbone, 8-bit registers in the low byte of each word
// Notes:   link pins pass two flip-flops before use; enables are active low
//
// The Wishbone interface to the registers was left to the implementer.
module spst_core
    import spst_pkg::*;
#(
    parameter int unsigned SS_IDLE_CYCLES = SS_IDLE_CYC
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // link pins
    input  wire spst_pin_s   pins_i,
    output spst_pin_s        pins_o,
    output spst_pin_s        pins_oe_n_o
);
    localparam logic [3:0] IDLE_MAX = 4'(SS_IDLE_CYCLES);

    if (SS_IDLE_CYCLES < 1 || SS_IDLE_CYCLES > 15)
    begin : g_chk
        $error("spst_core: SS_IDLE_CYCLES must be 1..15");
    end

    spst_core_s c_q;
    spst_core_s c_d;
    spst_pin_s  pin_s;
    logic       tick;
    logic       take;
    logic [7:0] idx;
    logic [7:0] stat;

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic lsbf);
        return lsbf ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shift_in

    function automatic logic out_bit(input logic [7:0] v, input logic lsbf);
        return lsbf ? v[0] : v[7];
    endfunction : out_bit

    spst_sync #(.W(4)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (pins_i),
        .q_o   (pin_s)
    );

    spst_tick u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .run_i  (c_q.st != ST_IDLE),
        .div_i  (c_q.baud),
        .tick_o (tick)
    );

    assign take = wb_cyc_i & wb_stb_i & ~c_q.ack;
    assign idx  = wb_adr_i[ADR_HI:ADR_LO];

    always_comb
    begin
        stat          = 8'h00;
        stat[ST_RXF]  = c_q.rxf;
        stat[ST_TXE]  = c_q.txe;
        stat[ST_MODE_FAULT_FLAG] = c_q.mode_fault_flag;
    end

    always_comb
    begin
        logic       en;
        logic       mst;
        logic       clock_phase_select;
        logic       lsbf;
        logic       ev;
        logic       sin;
        logic [4:0] n;
        en   = c_q.cr1[CR1_EN];
        mst  = c_q.cr1[CR1_MST];
        clock_phase_select = c_q.cr1[CR1_CLOCK_PHASE_SELECT];
        lsbf = c_q.cr1[CR1_LSBF];
        n    = c_q.edge_cnt + 5'h01;
        sin  = mst ? pin_s.miso : pin_s.mosi;
        ev   = en && (mst ? (c_q.st == ST_EDGE && tick)
                          : (!pin_s.ss_n && pin_s.sck != c_q.sck_prev));

        c_d          = c_q;
        c_d.ack      = take;
        c_d.sck_prev = pin_s.sck;
        c_d.ss_prev  = pin_s.ss_n;

        // bus side first, so that serial events below win over clears
        if (take)
        begin
            c_d.rdat = 8'h00;
            if (!wb_we_i)
            begin
                case (idx)
                    IDX_CTRL1:  c_d.rdat = c_q.cr1;
                    IDX_CTRL2:  c_d.rdat = c_q.cr2;
                    IDX_BAUD:   c_d.rdat = c_q.baud;
                    IDX_STATUS:
                    begin
                        c_d.rdat   = stat;
                        c_d.arm_rx = c_q.rxf;
                        c_d.arm_tx = c_q.txe;
                        c_d.arm_mf = c_q.mode_fault_flag;
                    end
                    IDX_DATA:
                    begin
                        c_d.rdat   = c_q.rx_data;
                        c_d.arm_rx = 1'b0;
                        if (c_q.arm_rx)
                            c_d.rxf = 1'b0;
                    end
                    default:    c_d.rdat = 8'h00;
                endcase
            end
            else if (wb_sel_i[0])
            begin
                case (idx)
                    IDX_CTRL1:
                    begin
                        c_d.cr1    = wb_dat_i[7:0];
                        c_d.arm_mf = 1'b0;
                        if (c_q.arm_mf)
                            c_d.mode_fault_flag = 1'b0;
                    end
                    IDX_CTRL2:  c_d.cr2  = wb_dat_i[7:0];
                    IDX_BAUD:   c_d.baud = wb_dat_i[7:0];
                    IDX_DATA:
                    begin
                        // unarmed writes are dropped without notice
                        c_d.arm_tx = 1'b0;
                        if (c_q.arm_tx)
                        begin
                            c_d.tx_buf = wb_dat_i[7:0];
                            c_d.txe    = 1'b0;
                        end
                    end
                    default:    c_d.rdat = 8'h00;   // status and holes ignore writes
                endcase
            end
        end

        // slave-select high time, saturating
        if (pin_s.ss_n)
        begin
            if (c_q.idle_cnt != IDLE_MAX)
                c_d.idle_cnt = c_q.idle_cnt + 4'h1;
        end
        else
            c_d.idle_cnt = 4'h0;

        // master sequencing
        unique case (c_q.st)
            ST_IDLE:
            begin
                c_d.po.sck  = c_q.cr1[CR1_CPOL];
                c_d.po.ss_n = 1'b1;
                if (en && mst && !c_q.txe && !c_q.mode_fault_flag)
                begin
                    c_d.st       = ST_LEAD;
                    c_d.shreg    = c_q.tx_buf;
                    c_d.txe      = 1'b1;
                    c_d.edge_cnt = 5'h00;
                    c_d.po.ss_n  = 1'b0;
                    if (!clock_phase_select)
                    begin
                        c_d.po.mosi = out_bit(c_q.tx_buf, lsbf);
                        c_d.po.miso = c_d.po.mosi;
                    end
                end
            end
            ST_LEAD:
                if (tick)
                    c_d.st = ST_EDGE;
            ST_EDGE:
                if (ev)
                begin
                    c_d.po.sck = ~c_q.po.sck;
                    if (n == XFER_EDGES)
                        c_d.st = ST_TRAIL;
                end
            ST_TRAIL:
                if (tick)
                begin
                    c_d.st      = ST_GAP;
                    c_d.po.ss_n = 1'b1;
                end
            ST_GAP:
                if (tick)
                    c_d.st = ST_IDLE;
        endcase

        // slave start on a select fall
        if (en && !mst && c_q.ss_prev && !pin_s.ss_n)
        begin
            c_d.edge_cnt = 5'h00;
            // a short high pulse keeps the received byte queued
            if (c_q.idle_cnt == IDLE_MAX)
            begin
                c_d.shreg = c_d.tx_buf;
                c_d.txe   = 1'b1;
            end
            if (!clock_phase_select)
            begin
                c_d.po.miso = out_bit(c_d.shreg, lsbf);
                c_d.po.mosi = c_d.po.miso;
            end
        end
        else if (!mst && pin_s.ss_n)
            c_d.edge_cnt = 5'h00;

        // common edge processing
        if (ev)
        begin
            c_d.edge_cnt = n;
            if (clock_phase_select ? !n[0] : n[0])
                c_d.latched = sin;
            if (clock_phase_select ? (n[0] && n >= 5'h03) : !n[0])
                c_d.shreg = shift_in(c_q.shreg, c_q.latched, lsbf);
            if (clock_phase_select && n == XFER_EDGES)
                c_d.shreg = shift_in(c_q.shreg, sin, lsbf);
            if (clock_phase_select ? n[0] : !n[0])
            begin
                c_d.po.mosi = out_bit(c_d.shreg, lsbf);
                c_d.po.miso = c_d.po.mosi;
            end
            if (n == XFER_EDGES)
            begin
                // shift register keeps the byte for a slave held selected
                c_d.edge_cnt = 5'h00;
                // a clearing data read in this cycle frees the register: set wins
                if (!c_d.rxf)
                begin
                    c_d.rx_data = c_d.shreg;
                    c_d.rxf     = 1'b1;
                end
            end
        end

        if (!en || !mst)
        begin
            c_d.st      = ST_IDLE;
            c_d.po.sck  = c_q.cr1[CR1_CPOL];
            c_d.po.ss_n = 1'b1;
        end

        if (en && mst && c_q.cr2[CR2_FDEN] && !c_q.cr1[CR1_SSOE]
            && c_q.ss_prev && !pin_s.ss_n)
        begin
            c_d.mode_fault_flag    = 1'b1;
            c_d.st      = ST_IDLE;
            c_d.po.sck  = c_q.cr1[CR1_CPOL];
            c_d.po.ss_n = 1'b1;
        end

        // a faulted master lets go of the link
        c_d.poe_n.sck  = !(en && mst && !c_q.mode_fault_flag);
        c_d.poe_n.mosi = !(en && mst && !c_q.mode_fault_flag);
        c_d.poe_n.ss_n = !(en && mst && c_q.cr1[CR1_SSOE] && !c_q.mode_fault_flag);
        c_d.poe_n.miso = !(en && !mst && !pin_s.ss_n);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            c_q          <= '0;
            c_q.st       <= ST_IDLE;
            c_q.cr1      <= CR1_RST;
            c_q.cr2      <= CR2_RST;
            c_q.baud     <= BAUD_RST;
            c_q.txe      <= STATUS_RST[ST_TXE];
            c_q.tx_buf   <= DATA_RST;
            c_q.idle_cnt <= IDLE_MAX;
            c_q.sck_prev <= 1'b1;
            c_q.ss_prev  <= 1'b1;
            c_q.po       <= '1;
            c_q.poe_n    <= '1;
        end
        else if (ce_i)
            c_q <= c_d;
    end

    assign wb_ack_o    = c_q.ack;
    assign wb_dat_o    = {24'h000000, c_q.rdat};
    assign pins_o      = c_q.po;
    assign pins_oe_n_o = c_q.poe_n;

    // helpers for the checks below
    logic [4:0] sck_toggles_q;
    logic       st_rd_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || c_q.st == ST_IDLE)
            sck_toggles_q <= 5'h00;
        else if (ce_i && c_d.po.sck != c_q.po.sck)
            sck_toggles_q <= sck_toggles_q + 5'h01;
        st_rd_q <= take && !wb_we_i && idx == IDX_STATUS;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    status_reserved_a: assert property (wb_ack_o && st_rd_q |-> wb_dat_o[6] == 1'b0 && wb_dat_o[3:0] == 4'h0) else $error("reserved status bits not zero");
    tx_empty_reset_a: assert property ($fell(rst_i) |-> c_q.txe && !c_q.rxf) else $error("status reset value wrong");
    data_wr_ignored_a: assert property (ce_i && take && wb_we_i && wb_sel_i[0] && idx == IDX_DATA && !c_q.arm_tx |=> $stable(c_q.tx_buf)) else $error("unarmed data write accepted");
    rx_flag_clear_a: assert property ($fell(c_q.rxf) |-> $past(take && !wb_we_i && idx == IDX_DATA && c_q.arm_rx)) else $error("receive flag cleared without sequence");
    fault_clear_a: assert property ($fell(c_q.mode_fault_flag) |-> $past(take && wb_we_i && idx == IDX_CTRL1 && c_q.arm_mf)) else $error("mode fault cleared without sequence");
    rx_hold_a: assert property ($past(c_q.rxf)
        && !$past(take && !wb_we_i && idx == IDX_DATA && c_q.arm_rx)
        |-> $stable(c_q.rx_data)) else $error("data register changed while flag set");
    sixteen_edges_a: assert property ($rose(c_q.st == ST_TRAIL) |-> sck_toggles_q == XFER_EDGES) else $error("transfer edge count not sixteen");
    lead_quiet_a: assert property (c_q.st == ST_LEAD |-> c_q.po.sck == c_q.cr1[CR1_CPOL] && !c_q.po.ss_n) else $error("clock moved during lead time");
    gap_select_a: assert property (c_q.st == ST_GAP |-> c_q.po.ss_n) else $error("select low during idle gap");
    tx_start_a: assert property (ce_i && c_q.st == ST_IDLE && c_q.cr1[CR1_EN] && c_q.cr1[CR1_MST] && !c_q.txe && !c_q.mode_fault_flag && !take |=> c_q.st == ST_LEAD && c_q.txe) else $error("queued byte not started");

    master_xfer_c: cover property (c_q.st == ST_GAP ##1 c_q.st == ST_IDLE);
    rx_done_c: cover property ($rose(c_q.rxf));
    fault_c: cover property ($rose(c_q.mode_fault_flag));
    overrun_hold_c: cover property (c_q.rxf && c_q.edge_cnt == 5'h0F && !c_q.cr1[CR1_MST]);

endmodule : spst_core

//--- dv/spst_slave_model.sv
// Purpose: external serial slave device facing the port in master mode
// Assumes: clock phase one, high bit first, select low for whole bytes
// Notes:   miso flips while deselected so a stale bit is never mistaken for data
module spst_slave_model
    import spst_pkg::*;
(
    // link
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       ss_n_i,
    output logic            miso_o,
    // bench side
    input  wire logic [7:0] tx_i,
    output logic      [7:0] rx_o,
    output logic            done_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] sh_q;
    logic [7:0] rx_q;
    int         edges;

    initial
    begin
        miso_o = 1'h0;
        done_o = 1'h0;
        rx_o   = 8'h00;
        edges  = 0;
    end

    always @(negedge ss_n_i)
    begin
        sh_q  = tx_i;
        edges = 0;
    end

    always @(posedge ss_n_i)
        miso_o = ~miso_o;

    always @(sck_i)
    begin
        if (ss_n_i === 1'h0)
        begin
            edges = edges + 1;
            if (edges % 2 == 1)
            begin
                miso_o = sh_q[7];
                sh_q   = {sh_q[6:0], 1'h0};
            end
            else
            begin
                rx_q = {rx_q[6:0], mosi_i};
                if (edges % 16 == 0)
                begin
                    rx_o   = rx_q;
                    done_o = ~done_o;
                end
            end
        end
    end
endmodule : spst_slave_model

//--- dv/spst_core_test.sv
// Purpose: self-checking bench for the serial status/transfer port
// Assumes: baud 7 so the three-cycle pin sampling lag stays inside a half period
// Notes:   select pin is pulled up when nobody drives it
module spst_core_test
    import spst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [31:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    spst_pin_s   pins_w;
    spst_pin_s   pins_o;
    spst_pin_s   pins_oe_n_o;
    logic        ss_ext;
    logic        sck_ext;
    logic        mosi_ext;
    logic        miso_w;
    logic        m_done;
    logic [7:0]  m_rx;
    logic [7:0]  slv_tx;
    logic [7:0]  rv;
    logic [8:0]  note;
    logic [7:0]  sb[3];
    logic [8:0]  nq[$];
    logic [7:0]  mq[$];
    int          n_errors;
    int          checks_done;
    int          cyc_cnt;
    int          n_m;

    always_comb
    begin
        pins_w.sck  = pins_oe_n_o.sck ? sck_ext : pins_o.sck;
        pins_w.mosi = pins_oe_n_o.mosi ? mosi_ext : pins_o.mosi;
        pins_w.miso = pins_oe_n_o.miso ? miso_w : pins_o.miso;
        pins_w.ss_n = pins_oe_n_o.ss_n ? ss_ext : pins_o.ss_n;
    end

    spst_core #(.SS_IDLE_CYCLES(7)) spst_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pins_i(pins_w), .pins_o(pins_o), .pins_oe_n_o(pins_oe_n_o));

    spst_slave_model spst_slave_model_inst (
        .sck_i(pins_w.sck), .mosi_i(pins_w.mosi), .ss_n_i(pins_w.ss_n),
        .miso_o(miso_w), .tx_i(slv_tx), .rx_o(m_rx), .done_o(m_done));

    task automatic fail(input string m);
        n_errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail

    task automatic end_sim;
        $display("errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // request held until the edge that samples ack
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'h1)
            @(posedge clk_i);
        rv = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : bus

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic c);
        nq.push_back({c, e});
        bus(1'h0, idx, 8'h00);
    endtask : rd

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'h1, idx, d);
    endtask : wr

    task automatic wait_bit(input int b);
        int k = 0;
        rd(IDX_STATUS, 8'h00, 1'h0);
        while (rv[b] !== 1'h1 && k < 200)
        begin
            rd(IDX_STATUS, 8'h00, 1'h0);
            k++;
        end
        if (rv[b] !== 1'h1)
            fail("status flag never set");
    endtask : wait_bit

    task automatic wait_m(input int n);
        int k = 0;
        while (n_m < n && k < 3000)
        begin
            @(posedge clk_i);
            k++;
        end
        if (n_m < n)
            fail("slave model saw no byte");
    endtask : wait_m

    // outside master, phase one, high bit first; half periods 6,6,6,7 cycles give 125 ns
    task automatic xfer_s(input logic [7:0] mo, output logic [7:0] mi);
        mi = 8'h00;
        for (int e = 1; e <= 16; e++)
        begin
            repeat ((e % 4 == 0) ? 7 : 6) @(posedge clk_i);
            sck_ext <= ~sck_ext;
            if (e % 2 == 1)
                mosi_ext <= mo[7 - (e - 1) / 2];
            else
                mi = {mi[6:0], pins_w.miso};
        end
        // trailing time after the last edge
        repeat (6) @(posedge clk_i);
    endtask : xfer_s

    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && nq.size() > 0)
        begin
            note = nq.pop_front();
            if (note[8])
            begin
                checks_done++;
                if (wb_dat_o !== {24'h0, note[7:0]})
                    fail("register read differs");
            end
        end
    end

    always @(m_done)
    begin
        if (cyc_cnt > 0)
        begin
            n_m++;
            checks_done++;
            if (mq.size() == 0 || m_rx !== mq.pop_front())
                fail("slave received wrong byte");
        end
    end

    // ceiling well above five transfers and the fault sequence
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            fail("timeout");
            end_sim();
        end
    end

    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        logic [7:0] b;
        logic [7:0] m1;
        logic [7:0] m2;
        logic [7:0] got;
        rst_i    = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i  = 1'h0;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        ss_ext   = 1'h1;
        sck_ext  = 1'h0;
        mosi_ext = 1'h1;
        wb_sel_i = 4'h0;
        slv_tx   = 8'h00;
        void'($urandom(74));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        wr(IDX_DATA, 8'h3C);
        rd(IDX_STATUS, STATUS_RST, 1'h1);
        wr(IDX_STATUS, 8'hFF);
        rd(IDX_STATUS, STATUS_RST, 1'h1);
        rd(8'h10, 8'h00, 1'h1);
        wr(IDX_BAUD, 8'h07);
        wr(IDX_CTRL1, 8'h56);
        for (int i = 0; i < 3; i++)
        begin
            sb[i] = 8'($urandom);
            b = 8'($urandom);
            slv_tx <= sb[i];
            mq.push_back(b);
            rd(IDX_STATUS, 8'h00, 1'h0);
            wr(IDX_DATA, b);
            wait_m(i + 1);
            wait_bit(ST_RXF);
            rd(IDX_STATUS, 8'hA0, 1'h1);
            // first byte left unread so that the second one overruns
            if (i != 0)
            begin
                rd(IDX_DATA, (i == 1) ? sb[0] : sb[i], 1'h1);
                rd(IDX_STATUS, STATUS_RST, 1'h1);
            end
        end
        // slave, phase one: a long select high loads the queued byte
        rd(IDX_STATUS, STATUS_RST, 1'h1);
        wr(IDX_CTRL1, 8'h44);
        b  = 8'($urandom);
        m1 = 8'($urandom);
        m2 = 8'($urandom);
        wr(IDX_DATA, b);
        repeat (10) @(posedge clk_i);
        mq.push_back(m1);
        mq.push_back(m2);
        ss_ext <= 1'h0;
        xfer_s(m1, got);
        checks_done++;
        if (got !== b)
            fail("slave sent wrong byte");
        // select held low, so the received byte comes back
        xfer_s(m2, got);
        checks_done++;
        if (got !== m1)
            fail("slave did not resend received byte");
        ss_ext <= 1'h1;
        rd(IDX_STATUS, 8'hA0, 1'h1);
        rd(IDX_DATA, m1, 1'h1);
        rd(IDX_STATUS, STATUS_RST, 1'h1);
        // select output off so an outside low select is a fault
        wr(IDX_CTRL1, 8'h54);
        wr(IDX_CTRL2, 8'h10);
        ss_ext <= 1'h0;
        wait_bit(ST_MODE_FAULT_FLAG);
        ss_ext <= 1'h1;
        rd(IDX_STATUS, 8'h30, 1'h1);
        wr(IDX_CTRL1, 8'h54);
        rd(IDX_STATUS, STATUS_RST, 1'h1);
        end_sim();
    end
endmodule : spst_core_test
